// ===== src/pps_pkg.sv
// pps_pkg: constants for the parallel I/O pattern selector
// assumes one 50 MHz clock and a motion core on the same clock
package pps_pkg;
   localparam int CLK_PERIOD_NS = 20;
   localparam int SYNC_STAGES = 3;

   // pattern codes as set in the configuration parameter
   localparam logic [2:0] PAT_POSITIONING = 3'h0;
   localparam logic [2:0] PAT_TEACHING = 3'h1;
   localparam logic [2:0] PAT_POINTS_256 = 3'h2;
   localparam logic [2:0] PAT_POINTS_512 = 3'h3;
   localparam logic [2:0] PAT_SOLENOID_1 = 3'h4;
   localparam logic [2:0] PAT_SOLENOID_2 = 3'h5;
   localparam logic [2:0] PAT_LAST = 3'h5;
   localparam logic [2:0] PAT_RESET = 3'h0;

   // stored positions reachable per pattern
   localparam logic [9:0] POINTS_64 = 10'h040;
   localparam logic [9:0] POINTS_256 = 10'h100;
   localparam logic [9:0] POINTS_512 = 10'h200;
   localparam logic [9:0] POINTS_SOL_1 = 10'h007;
   localparam logic [9:0] POINTS_SOL_2 = 10'h003;

   // widths
   localparam int INDEX_W = 9;
   localparam int DIRECT_W = 7;
   localparam int POS_W = 16;
   localparam int HOST_W = 23;

   // field positions of the synchronised host input vector
   localparam int HB_CODE = 0;
   localparam int HB_START = 9;
   localparam int HB_DIRECT = 10;
   localparam int HB_HOME = 17;
   localparam int HB_PAUSE_N = 18;
   localparam int HB_JOG_PLUS = 19;
   localparam int HB_JOG_MINUS = 20;
   localparam int HB_TEACH = 21;
   localparam int HB_BRAKE = 22;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT,
      ST_RUN
   } pps_state_t;
endpackage

// ===== src/pps_in_sync.sv
// pps_in_sync: three-stage synchroniser for host pins, per bit
// assumes the pins are asynchronous to clock_i
`timescale 1ns/10ps
module pps_in_sync #(
   parameter int W = 1
) (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] level_o
);
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         logic s1_reg;
         logic s2_reg;
         logic s3_reg;
         logic lvl_reg;
         // first stage feeds only the second
         always_ff @(posedge clock_i) begin
            if (reset_i) begin
               s1_reg <= 1'b0;
               s2_reg <= 1'b0;
               s3_reg <= 1'b0;
            end else begin
               s1_reg <= pin_i[g];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
            end
         end
         // a change counts once stages two and three agree
         always_ff @(posedge clock_i) begin
            if (reset_i) begin
               lvl_reg <= 1'b0;
            end else if (s2_reg == s3_reg) begin
               lvl_reg <= s3_reg;
            end
         end
         assign level_o[g] = lvl_reg;
      end
   endgenerate
endmodule

// ===== src/pps_region_cmp.sv
// pps_region_cmp: inclusive window test of a coordinate
// assumes lower bound not above upper bound; otherwise never inside
`timescale 1ns/10ps
module pps_region_cmp (
   input wire logic [pps_pkg::POS_W-1:0] pos_i,
   input wire logic [pps_pkg::POS_W-1:0] lo_i,
   input wire logic [pps_pkg::POS_W-1:0] hi_i,
   output logic inside_o
);
   assign inside_o = (pos_i >= lo_i) && (pos_i <= hi_i);
endmodule

// ===== src/pps_pattern_select.sv
// pps_pattern_select: gates host parallel inputs and status outputs
// by the selected I/O pattern, issues commands to the motion core
// assumes motion core and coordinates on clock_i; host pins asynchronous
//
// Summary of operation
// - six patterns 0-5 picked by configuration
// - pattern fixed while running or moving
// - addressable positions depend on pattern
// - patterns 0-3: binary index then start
// - patterns 4-5: per-position input starts move
// - velocity change mid-move only patterns 0-3
// - pressing allowed in patterns 0-4
// - pitch feed allowed in patterns 0-4
// - home input only in patterns 0-4
// - pause input in patterns 0-4
// - pattern 5 has no pause
// - jog only pattern 1, while held
// - teach only pattern 1, writes position
// - brake release all but pattern 1
// - moving output in patterns 0 and 1
// - parameter zones 0,4,5, after homing only
// - entry zone except pattern 3, selected entry
// - pause input active low, low stops
`timescale 1ns/10ps
module pps_pattern_select (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic [2:0] cfg_pattern_i,
   input wire logic cfg_load_i,
   input wire logic [pps_pkg::INDEX_W-1:0] pos_code_i,
   input wire logic start_i,
   input wire logic [pps_pkg::DIRECT_W-1:0] per_position_start_i,
   input wire logic home_i,
   input wire logic pause_hold_n_i,
   input wire logic jog_plus_i,
   input wire logic jog_minus_i,
   input wire logic teach_i,
   input wire logic brake_release_i,
   input wire logic moving_i,
   input wire logic home_done_i,
   input wire logic [pps_pkg::POS_W-1:0] cur_pos_i,
   input wire logic [pps_pkg::POS_W-1:0] zone_a_lo_i,
   input wire logic [pps_pkg::POS_W-1:0] zone_a_hi_i,
   input wire logic [pps_pkg::POS_W-1:0] zone_b_lo_i,
   input wire logic [pps_pkg::POS_W-1:0] zone_b_hi_i,
   input wire logic [pps_pkg::POS_W-1:0] entry_lo_i,
   input wire logic [pps_pkg::POS_W-1:0] entry_hi_i,
   input wire logic entry_push_i,
   input wire logic entry_rel_i,
   output logic [2:0] pattern_o,
   output logic pattern_valid_o,
   output logic [9:0] point_count_o,
   output logic cmd_start_o,
   output logic [pps_pkg::INDEX_W-1:0] cmd_index_o,
   output logic cmd_vel_change_o,
   output logic cmd_push_o,
   output logic cmd_rel_o,
   output logic cmd_home_o,
   output logic cmd_pause_o,
   output logic cmd_jog_plus_o,
   output logic cmd_jog_minus_o,
   output logic cmd_teach_o,
   output logic brake_release_o,
   output logic moving_o,
   output logic param_region_out_a_o,
   output logic param_region_out_b_o,
   output logic entry_region_out_o
);
   logic [pps_pkg::HOST_W-1:0] host_raw;
   logic [pps_pkg::HOST_W-1:0] host_lvl;
   logic [pps_pkg::HOST_W-1:0] host_prev_reg;
   logic [pps_pkg::INDEX_W-1:0] code_sync;
   logic [pps_pkg::DIRECT_W-1:0] direct_sync;
   logic [pps_pkg::DIRECT_W-1:0] direct_rise;
   logic start_rise;
   logic home_rise;
   logic teach_rise;
   logic [2:0] pattern_reg;
   logic pattern_valid_reg;
   logic [9:0] point_count_reg;
   pps_pkg::pps_state_t state_reg;
   pps_pkg::pps_state_t state_next;
   logic binary_en;
   logic direct_en;
   logic push_en;
   logic home_en;
   logic pause_en;
   logic jog_en;
   logic brake_en;
   logic moving_en;
   logic zone_en;
   logic entry_zone_en;
   logic [pps_pkg::INDEX_W-1:0] req_index;
   logic start_fire;
   logic busy;
   logic entry_sel_reg;
   logic [pps_pkg::INDEX_W-1:0] cmd_index_reg;
   logic in_a;
   logic in_b;
   logic in_entry;

   assign host_raw = {brake_release_i, teach_i, jog_minus_i, jog_plus_i, pause_hold_n_i,
                      home_i, per_position_start_i, start_i, pos_code_i};

   pps_in_sync #(.W(pps_pkg::HOST_W)) u_sync (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .pin_i(host_raw),
      .level_o(host_lvl)
   );

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         host_prev_reg <= '0;
      end else begin
         host_prev_reg <= host_lvl;
      end
   end

   assign code_sync = host_lvl[pps_pkg::HB_CODE +: pps_pkg::INDEX_W];
   assign direct_sync = host_lvl[pps_pkg::HB_DIRECT +: pps_pkg::DIRECT_W];
   assign direct_rise = direct_sync & ~host_prev_reg[pps_pkg::HB_DIRECT +: pps_pkg::DIRECT_W];
   assign start_rise = host_lvl[pps_pkg::HB_START] & ~host_prev_reg[pps_pkg::HB_START];
   assign home_rise = host_lvl[pps_pkg::HB_HOME] & ~host_prev_reg[pps_pkg::HB_HOME];
   assign teach_rise = host_lvl[pps_pkg::HB_TEACH] & ~host_prev_reg[pps_pkg::HB_TEACH];

   // configuration latch; refused while any motion is pending or running
   assign busy = (state_reg != pps_pkg::ST_IDLE) || moving_i;

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         pattern_reg <= pps_pkg::PAT_RESET;
         pattern_valid_reg <= 1'b1;
      end else if (cfg_load_i && !busy && !start_fire) begin
         pattern_reg <= cfg_pattern_i;
         pattern_valid_reg <= (cfg_pattern_i <= pps_pkg::PAT_LAST);
      end
   end

   // feature enables per pattern; an invalid code enables nothing
   always_comb begin
      binary_en = 1'b0;
      direct_en = 1'b0;
      push_en = 1'b0;
      home_en = 1'b0;
      pause_en = 1'b0;
      jog_en = 1'b0;
      brake_en = 1'b0;
      moving_en = 1'b0;
      zone_en = 1'b0;
      entry_zone_en = 1'b0;
      if (pattern_valid_reg) begin
         binary_en = (pattern_reg <= pps_pkg::PAT_POINTS_512);
         direct_en = (pattern_reg >= pps_pkg::PAT_SOLENOID_1);
         push_en = (pattern_reg != pps_pkg::PAT_SOLENOID_2);
         home_en = (pattern_reg != pps_pkg::PAT_SOLENOID_2);
         pause_en = (pattern_reg != pps_pkg::PAT_SOLENOID_2);
         jog_en = (pattern_reg == pps_pkg::PAT_TEACHING);
         brake_en = (pattern_reg != pps_pkg::PAT_TEACHING);
         moving_en = (pattern_reg <= pps_pkg::PAT_TEACHING);
         zone_en = (pattern_reg == pps_pkg::PAT_POSITIONING) ||
                   (pattern_reg >= pps_pkg::PAT_SOLENOID_1);
         entry_zone_en = (pattern_reg != pps_pkg::PAT_POINTS_512);
      end
   end

   // request index: binary code cut to the pattern's range, or the
   // lowest newly raised direct input; several at once is host misuse
   always_comb begin
      req_index = '0;
      start_fire = 1'b0;
      if (binary_en) begin
         unique case (pattern_reg)
            pps_pkg::PAT_POINTS_256: req_index = {1'b0, code_sync[7:0]};
            pps_pkg::PAT_POINTS_512: req_index = code_sync;
            default: req_index = {3'h0, code_sync[5:0]};
         endcase
         start_fire = start_rise;
      end else if (direct_en) begin
         for (int i = pps_pkg::DIRECT_W - 1; i >= 0; i--) begin
            if (direct_rise[i] && (i < int'(point_count_reg))) begin
               req_index = pps_pkg::INDEX_W'(i);
               start_fire = 1'b1;
            end
         end
         // solenoid patterns cannot retarget a move in flight
         if (busy) begin
            start_fire = 1'b0;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         point_count_reg <= pps_pkg::POINTS_64;
      end else begin
         unique case (pattern_reg)
            pps_pkg::PAT_POINTS_256: point_count_reg <= pps_pkg::POINTS_256;
            pps_pkg::PAT_POINTS_512: point_count_reg <= pps_pkg::POINTS_512;
            pps_pkg::PAT_SOLENOID_1: point_count_reg <= pps_pkg::POINTS_SOL_1;
            pps_pkg::PAT_SOLENOID_2: point_count_reg <= pps_pkg::POINTS_SOL_2;
            default: point_count_reg <= pattern_valid_reg ? pps_pkg::POINTS_64 : 10'h000;
         endcase
      end
   end

   // move tracking: wait for the core to report motion, then its end
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         pps_pkg::ST_IDLE: if (start_fire || (home_rise && home_en)) state_next = pps_pkg::ST_WAIT;
         pps_pkg::ST_WAIT: if (moving_i) state_next = pps_pkg::ST_RUN;
         pps_pkg::ST_RUN: if (!moving_i) state_next = pps_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         state_reg <= pps_pkg::ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // start, index and per-move options
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         cmd_start_o <= 1'b0;
         cmd_vel_change_o <= 1'b0;
         cmd_push_o <= 1'b0;
         cmd_rel_o <= 1'b0;
         cmd_index_reg <= '0;
         entry_sel_reg <= 1'b0;
      end else begin
         cmd_start_o <= start_fire;
         cmd_vel_change_o <= start_fire && binary_en && moving_i;
         if (start_fire) begin
            cmd_push_o <= entry_push_i && push_en;
            cmd_rel_o <= entry_rel_i && push_en;
            cmd_index_reg <= req_index;
            entry_sel_reg <= 1'b1;
         end else if (teach_rise && jog_en && !moving_i) begin
            cmd_index_reg <= req_index;
         end
         if (!pattern_valid_reg) begin
            entry_sel_reg <= 1'b0;
         end
      end
   end
   assign cmd_index_o = cmd_index_reg;

   // home, pause, jog, teach and brake
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         cmd_home_o <= 1'b0;
         cmd_pause_o <= 1'b0;
         cmd_jog_plus_o <= 1'b0;
         cmd_jog_minus_o <= 1'b0;
         cmd_teach_o <= 1'b0;
         brake_release_o <= 1'b0;
      end else begin
         cmd_home_o <= home_rise && home_en && !start_fire;
         cmd_pause_o <= pause_en && !host_lvl[pps_pkg::HB_PAUSE_N];
         cmd_jog_plus_o <= jog_en && host_lvl[pps_pkg::HB_JOG_PLUS];
         cmd_jog_minus_o <= jog_en && host_lvl[pps_pkg::HB_JOG_MINUS];
         // teach only while stopped, so the written coordinate is settled
         cmd_teach_o <= jog_en && teach_rise && !moving_i;
         brake_release_o <= brake_en && host_lvl[pps_pkg::HB_BRAKE];
      end
   end

   pps_region_cmp u_zone_a (
      .pos_i(cur_pos_i),
      .lo_i(zone_a_lo_i),
      .hi_i(zone_a_hi_i),
      .inside_o(in_a)
   );

   pps_region_cmp u_zone_b (
      .pos_i(cur_pos_i),
      .lo_i(zone_b_lo_i),
      .hi_i(zone_b_hi_i),
      .inside_o(in_b)
   );

   pps_region_cmp u_zone_entry (
      .pos_i(cur_pos_i),
      .lo_i(entry_lo_i),
      .hi_i(entry_hi_i),
      .inside_o(in_entry)
   );

   // status outputs
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         moving_o <= 1'b0;
         param_region_out_a_o <= 1'b0;
         param_region_out_b_o <= 1'b0;
         entry_region_out_o <= 1'b0;
      end else begin
         moving_o <= moving_en && moving_i;
         // coordinates mean nothing before homing, so parameter zones stay low
         param_region_out_a_o <= zone_en && home_done_i && in_a;
         param_region_out_b_o <= zone_en && home_done_i && in_b;
         entry_region_out_o <= entry_zone_en && entry_sel_reg && in_entry;
      end
   end

   assign pattern_o = pattern_reg;
   assign pattern_valid_o = pattern_valid_reg;
   assign point_count_o = point_count_reg;

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (reset_i);

   a_pattern_held: assert property ((state_reg != pps_pkg::ST_IDLE) |=> $stable(pattern_reg))
      else $error("pattern changed during motion");
   a_invalid_quiet: assert property (!pattern_valid_reg |=> !cmd_start_o && !cmd_home_o)
      else $error("motion command with invalid pattern");
   a_start_index: assert property (start_fire |=> cmd_start_o && cmd_index_o == $past(req_index))
      else $error("start or index not issued");
   a_direct_start: assert property (direct_en && !busy && direct_rise[0] |=> cmd_start_o && cmd_index_o == '0)
      else $error("direct input did not start position 0");
   a_vel_change: assert property (cmd_vel_change_o |-> cmd_start_o && $past(binary_en))
      else $error("velocity change outside binary patterns");
   a_home_gate: assert property (!home_en |=> !cmd_home_o)
      else $error("home command in pattern 5");
   a_pause_map: assert property (pause_en && !host_lvl[pps_pkg::HB_PAUSE_N] ##1 pause_en |-> cmd_pause_o)
      else $error("pause not applied");
   a_no_pause_p5: assert property ((pattern_reg == pps_pkg::PAT_SOLENOID_2) [*2] |-> !cmd_pause_o)
      else $error("pause in pattern 5");
   a_jog_gate: assert property (!jog_en |=> !cmd_jog_plus_o && !cmd_jog_minus_o && !cmd_teach_o)
      else $error("jog or teach outside pattern 1");
   a_brake_gate: assert property (!brake_en |=> !brake_release_o)
      else $error("brake released in pattern 1");
   a_moving_map: assert property (moving_en && moving_i ##1 moving_en |-> moving_o)
      else $error("moving not reported");
   a_zone_homed: assert property (!home_done_i |=> !param_region_out_a_o && !param_region_out_b_o)
      else $error("zone output before homing");
   a_entry_zone: assert property (!entry_zone_en |=> !entry_region_out_o)
      else $error("entry zone in pattern 3");

   c_binary_move: cover property (binary_en && start_fire ##[1:20] state_reg == pps_pkg::ST_RUN);
   c_direct_move: cover property (direct_en && cmd_start_o);
   c_paused: cover property (moving_i && cmd_pause_o);
   c_zone_hit: cover property (param_region_out_a_o && entry_region_out_o);
endmodule

// ===== tb/pps_motion_model.sv
// pps_motion_model: behavioural motion core behind the pattern selector
// assumes commands arrive as one-cycle pulses on clock_i
`timescale 1ns/10ps
module pps_motion_model (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic cmd_start_i,
   input wire logic cmd_home_i,
   input wire logic slow_i,
   output logic moving_o,
   output logic home_done_o,
   output logic [15:0] cur_pos_o
);
   logic [2:0] wait_reg;
   logic [7:0] run_reg;
   logic homing_reg;

   // always answers: the selector waits for motion without limit
   // a start seen while moving only changes speed, so length is kept
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         wait_reg <= 3'h0;
         run_reg <= 8'h00;
         homing_reg <= 1'b0;
         moving_o <= 1'b0;
         home_done_o <= 1'b0;
         cur_pos_o <= 16'h0000;
      end else if (!moving_o && wait_reg == 3'h0 && (cmd_start_i || cmd_home_i)) begin
         wait_reg <= slow_i ? 3'h4 : 3'h1;
         homing_reg <= cmd_home_i;
      end else if (wait_reg != 3'h0) begin
         wait_reg <= wait_reg - 3'h1;
         if (wait_reg == 3'h1) begin
            moving_o <= 1'b1;
            run_reg <= 8'h32;
         end
      end else if (moving_o) begin
         cur_pos_o <= cur_pos_o + 16'h0001;
         run_reg <= run_reg - 8'h01;
         if (run_reg == 8'h01) begin
            moving_o <= 1'b0;
            home_done_o <= home_done_o | homing_reg;
         end
      end
   end
endmodule

// ===== tb/tb.sv
// tb: self-checking bench for the parallel I/O pattern selector
// assumes the motion model answers every start and home command
`timescale 1ns/10ps
module tb;
   localparam logic [5:0] M_VEL = 6'h0F;
   localparam logic [5:0] M_PUSH = 6'h1F;
   localparam logic [5:0] M_JOG = 6'h02;
   localparam logic [5:0] M_BRK = 6'h3D;
   localparam logic [5:0] M_MOV = 6'h03;
   localparam logic [5:0] M_ZONE = 6'h31;
   localparam logic [5:0] M_ENT = 6'h37;
   logic clock_i, reset_i, cfg_load_i, start_i, home_i, pause_hold_n_i, teach_i;
   logic jog_plus_i, jog_minus_i, brake_release_i, entry_push_i, entry_rel_i, slow;
   logic [2:0] cfg_pattern_i, pattern_o;
   logic [8:0] pos_code_i, cmd_index_o;
   logic [6:0] per_position_start_i;
   logic [15:0] zlo, zhi, cur_pos;
   logic [9:0] point_count_o;
   logic moving, home_done, pattern_valid_o, cmd_start_o, cmd_vel_change_o, cmd_push_o;
   logic cmd_rel_o, cmd_home_o, cmd_pause_o, cmd_jog_plus_o, cmd_jog_minus_o, cmd_teach_o;
   logic brake_release_o, moving_o, reg_a, reg_b, reg_e;
   int n_errors, n_checks, n_start, n_vel, n_home, n_teach, seed_val;

   pps_pattern_select i_pps_pattern_select (
      .clock_i(clock_i), .reset_i(reset_i), .cfg_pattern_i(cfg_pattern_i),
      .cfg_load_i(cfg_load_i), .pos_code_i(pos_code_i), .start_i(start_i),
      .per_position_start_i(per_position_start_i), .home_i(home_i),
      .pause_hold_n_i(pause_hold_n_i), .jog_plus_i(jog_plus_i), .jog_minus_i(jog_minus_i),
      .teach_i(teach_i), .brake_release_i(brake_release_i), .moving_i(moving),
      .home_done_i(home_done), .cur_pos_i(cur_pos), .zone_a_lo_i(zlo), .zone_a_hi_i(zhi),
      .zone_b_lo_i(zlo), .zone_b_hi_i(zhi), .entry_lo_i(zlo), .entry_hi_i(zhi),
      .entry_push_i(entry_push_i), .entry_rel_i(entry_rel_i), .pattern_o(pattern_o),
      .pattern_valid_o(pattern_valid_o), .point_count_o(point_count_o),
      .cmd_start_o(cmd_start_o), .cmd_index_o(cmd_index_o),
      .cmd_vel_change_o(cmd_vel_change_o), .cmd_push_o(cmd_push_o), .cmd_rel_o(cmd_rel_o),
      .cmd_home_o(cmd_home_o), .cmd_pause_o(cmd_pause_o), .cmd_jog_plus_o(cmd_jog_plus_o),
      .cmd_jog_minus_o(cmd_jog_minus_o), .cmd_teach_o(cmd_teach_o),
      .brake_release_o(brake_release_o), .moving_o(moving_o),
      .param_region_out_a_o(reg_a), .param_region_out_b_o(reg_b),
      .entry_region_out_o(reg_e)
   );

   pps_motion_model i_pps_motion_model (
      .clock_i(clock_i), .reset_i(reset_i), .cmd_start_i(cmd_start_o),
      .cmd_home_i(cmd_home_o), .slow_i(slow), .moving_o(moving),
      .home_done_o(home_done), .cur_pos_o(cur_pos)
   );

   initial begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end

   // pulses counted at the edge, each high cycle once
   always @(posedge clock_i) begin
      if (cmd_start_o === 1'b1) n_start++;
      if (cmd_vel_change_o === 1'b1) n_vel++;
      if (cmd_home_o === 1'b1) n_home++;
      if (cmd_teach_o === 1'b1) n_teach++;
   end

   function automatic logic has(input logic [5:0] m, input int p);
      return (p < 6) ? m[p] : 1'b0;
   endfunction

   function automatic logic [9:0] exp_points(input int p);
      case (p)
         0, 1: return 10'h040;
         2: return 10'h100;
         3: return 10'h200;
         4: return 10'h007;
         5: return 10'h003;
         default: return 10'h000;
      endcase
   endfunction

   task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clock_i);
   endtask

   task automatic wait_idle;
      int i;
      i = 0;
      while (moving !== 1'b0 && i < 300) begin
         cyc(1);
         i++;
      end
      chk("idle", 16'h0000, {15'h0000, moving});
   endtask

   task automatic press(input int p, input int k, input logic [8:0] code);
      if (p == 4 || p == 5) per_position_start_i = 7'h01 << k;
      else pos_code_i = code;
      cyc(4);
      start_i = !(p == 4 || p == 5);
   endtask

   task automatic run_pattern(input int p);
      int k, s0, v0;
      logic [8:0] idx;
      logic push, rel;
      cyc(1);
      cfg_pattern_i = p[2:0];
      cfg_load_i = 1'b1;
      slow = 1'($urandom % 2);
      cyc(1);
      cfg_load_i = 1'b0;
      chk("pattern", 16'(p), {13'h0000, pattern_o});
      chk("valid", {15'h0000, p < 6}, {15'h0000, pattern_valid_o});
      cyc(1);
      chk("points", {6'h00, exp_points(p)}, {6'h00, point_count_o});
      pause_hold_n_i = 1'b0;
      jog_plus_i = 1'b1;
      brake_release_i = 1'b1;
      cyc(8);
      chk("pause", {15'h0000, has(M_PUSH, p)}, {15'h0000, cmd_pause_o});
      chk("jog_plus", {15'h0000, has(M_JOG, p)}, {15'h0000, cmd_jog_plus_o});
      chk("brake", {15'h0000, has(M_BRK, p)}, {15'h0000, brake_release_o});
      pause_hold_n_i = 1'b1;
      jog_plus_i = 1'b0;
      jog_minus_i = 1'b1;
      brake_release_i = 1'b0;
      cyc(8);
      chk("pause", 16'h0000, {15'h0000, cmd_pause_o});
      chk("jog_minus", {15'h0000, has(M_JOG, p)}, {15'h0000, cmd_jog_minus_o});
      chk("brake", 16'h0000, {15'h0000, brake_release_o});
      jog_minus_i = 1'b0;
      // corners: highest index of the 512 table, last and first direct input
      push = 1'($urandom % 2);
      rel = 1'($urandom % 2);
      entry_push_i = push;
      entry_rel_i = rel;
      k = (p == 4) ? 6 : 0;
      idx = (p == 3) ? 9'h1FF : 9'($urandom % ((p < 4) ? int'(exp_points(p)) : 64));
      if (p == 4 || p == 5) idx = 9'(k);
      s0 = n_start;
      press(p, k, idx);
      cyc(10);
      chk("starts", {15'h0000, p < 6}, 16'(n_start - s0));
      if (p < 6) begin
         chk("index", {7'h00, idx}, {7'h00, cmd_index_o});
         chk("push", {15'h0000, push && has(M_PUSH, p)}, {15'h0000, cmd_push_o});
         chk("rel", {15'h0000, rel && has(M_PUSH, p)}, {15'h0000, cmd_rel_o});
         cyc(4);
         chk("moving", {15'h0000, has(M_MOV, p)}, {15'h0000, moving_o});
         chk("entry", {15'h0000, has(M_ENT, p)}, {15'h0000, reg_e});
         chk("zone_a", {15'h0000, has(M_ZONE, p) && home_done}, {15'h0000, reg_a});
         chk("zone_b", {15'h0000, has(M_ZONE, p) && home_done}, {15'h0000, reg_b});
         start_i = 1'b0;
         per_position_start_i = 7'h00;
         cfg_pattern_i = 3'((p + 1) % 6);
         cfg_load_i = 1'b1;
         cyc(1);
         cfg_load_i = 1'b0;
         s0 = n_start;
         v0 = n_vel;
         press(p, (k + 1) % int'(exp_points(p)), idx ^ 9'h001);
         cyc(10);
         chk("vel_start", {15'h0000, has(M_VEL, p)}, 16'(n_start - s0));
         chk("vel_change", {15'h0000, has(M_VEL, p)}, 16'(n_vel - v0));
         chk("pattern_held", 16'(p), {13'h0000, pattern_o});
      end
      start_i = 1'b0;
      per_position_start_i = 7'h00;
      wait_idle();
      s0 = n_home;
      home_i = 1'b1;
      cyc(10);
      chk("home", {15'h0000, has(M_PUSH, p)}, 16'(n_home - s0));
      home_i = 1'b0;
      wait_idle();
      // zone output lags home done by one edge
      cyc(1);
      chk("zone_a", {15'h0000, has(M_ZONE, p) && home_done}, {15'h0000, reg_a});
      zlo = 16'hFFFF;
      cyc(3);
      chk("zone_out", 16'h0000, {13'h0000, reg_a, reg_b, reg_e});
      zlo = 16'h0000;
      s0 = n_teach;
      pos_code_i = 9'($urandom % 64);
      teach_i = 1'b1;
      cyc(10);
      chk("teach", {15'h0000, has(M_JOG, p)}, 16'(n_teach - s0));
      if (p == 1) chk("teach_index", {7'h00, pos_code_i}, {7'h00, cmd_index_o});
      teach_i = 1'b0;
      cyc(4);
   endtask

   task automatic summarize;
      if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      {cfg_load_i, start_i, home_i, teach_i, jog_plus_i, jog_minus_i} = 6'h00;
      {brake_release_i, entry_push_i, entry_rel_i, slow} = 4'h0;
      cfg_pattern_i = 3'h0;
      pos_code_i = 9'h000;
      per_position_start_i = 7'h00;
      pause_hold_n_i = 1'b1;
      zlo = 16'h0000;
      zhi = 16'hFFFF;
      reset_i = 1'b1;
      seed_val = $urandom(32'hBF34);
      repeat (16) @(negedge clock_i);
      reset_i = 1'b0;
      chk("pattern", 16'h0000, {13'h0000, pattern_o});
      chk("points", 16'h0040, {6'h00, point_count_o});
      cyc(8);
      for (int p = 0; p < 8; p++) run_pattern(p);
      summarize();
   end

   // about 160 cycles per valid pattern are expected
   initial begin
      repeat (20000) @(posedge clock_i);
      n_errors++;
      summarize();
   end
endmodule
